// ---- src/idd_consts.svh ----
// constants for the increment, decrement and divide-step block
`ifndef IDD_CONSTS_SVH
`define IDD_CONSTS_SVH
`define IDD_WORD_W    16
`define IDD_ACC_W     32
`define IDD_SEL_W     3
`define IDD_SHORT_W   6
`define IDD_N_ACC     2
`define IDD_N_XIN     3
`define IDD_N_PTR     5
`define IDD_SP_IDX    3'h4
`define IDD_ONE       16'h0001
`define IDD_LOW_ZERO  16'h0000
`define IDD_SHORT_PAD 10'h000
`define IDD_DIV_BITS  5'h10
`define IDD_CNT_W     5
`define IDD_CNT_ONE   5'h01
`endif

// ---- src/idd_pkg.sv ----
// shared types for the increment, decrement and divide-step block
`include "idd_consts.svh"
package idd_pkg;
  typedef enum logic [2:0] {OP_NOP, OP_INCREMENT_WORD, OP_DECREMENT_WORD, OP_LEA_INC, OP_LEA_DEC,
    OP_TEST_WORD_AND_DECREMENT_DEC, OP_TEST_WORD_AND_DECREMENT_ACC, OP_DIV} idd_op_t;
  typedef enum logic [1:0] {DST_ACC, DST_XIN, DST_PTR, DST_MEM} idd_dst_t;
  typedef enum logic [1:0] {AM_SHORT, AM_ABS, AM_STACK} idd_am_t;
  typedef enum logic [1:0] {ALU_INC, ALU_DEC, ALU_TST, ALU_DIV} idd_alu_t;
  typedef struct packed {
    logic                      valid;
    idd_op_t                   op;
    idd_dst_t                  dst;
    idd_am_t                   am;
    logic [`IDD_SEL_W-1:0]     sel;
    logic [`IDD_WORD_W-1:0]    operand;
  } idd_instr_t;
  typedef struct packed {
    logic c;
    logic v;
    logic z;
    logic n;
  } idd_flags_t;
  typedef struct packed {
    logic                   rd;
    logic                   wr;
    logic [`IDD_WORD_W-1:0] addr;
    logic [`IDD_WORD_W-1:0] wdata;
  } idd_xreq_t;
  typedef struct packed {
    logic [`IDD_N_ACC-1:0][`IDD_ACC_W-1:0]  acc;
    logic [`IDD_N_XIN-1:0][`IDD_WORD_W-1:0] xin;
    logic [`IDD_N_PTR-1:0][`IDD_WORD_W-1:0] ptr;
  } idd_regs_t;
endpackage

// ---- src/idd_alu_step.sv ----
// word add/subtract, test and one non-restoring divide step
`timescale 1ns/1ps
`include "idd_consts.svh"
module idd_alu_step
  import idd_pkg::*;
(
  input idd_pkg::idd_alu_t        op,
  logic [`IDD_ACC_W-1:0]          opa,
  logic [`IDD_WORD_W-1:0]         divisor,
  logic                           c_in,
  output logic [`IDD_ACC_W-1:0]   res,
  output idd_pkg::idd_flags_t     flags
);
  logic [`IDD_ACC_W:0]    sum;
  logic [`IDD_ACC_W-1:0]  shl;
  logic [`IDD_WORD_W:0]   up;
  logic                   qbit;

  // --------------------------------------------------------------
  // datapath
  // --------------------------------------------------------------
  // word operands sit in the upper half, so one adder serves increment and decrement at both widths
  always_comb
  begin
    sum   = '0;
    shl   = {opa[`IDD_ACC_W-2:0], c_in};
    up    = '0;
    qbit  = 1'b0;
    res   = opa;
    flags = '0;
    case (op)
      ALU_INC:
      begin
        sum   = {1'b0, opa} + {1'b0, `IDD_ONE, `IDD_LOW_ZERO};
        res   = sum[`IDD_ACC_W-1:0];
        flags.c = sum[`IDD_ACC_W];
        flags.v = ~opa[`IDD_ACC_W-1] & res[`IDD_ACC_W-1];
      end
      ALU_DEC:
      begin
        sum   = {1'b0, opa} - {1'b0, `IDD_ONE, `IDD_LOW_ZERO};
        res   = sum[`IDD_ACC_W-1:0];
        flags.c = sum[`IDD_ACC_W];
        flags.v = opa[`IDD_ACC_W-1] & ~res[`IDD_ACC_W-1];
      end
      ALU_DIV:
      begin
        // add when signs differ, else subtract; carry is the quotient bit
        if (opa[`IDD_ACC_W-1] ^ divisor[`IDD_WORD_W-1])
          up = {1'b0, shl[`IDD_ACC_W-1:`IDD_WORD_W]} + {1'b0, divisor};
        else
          up = {1'b0, shl[`IDD_ACC_W-1:`IDD_WORD_W]} - {1'b0, divisor};
        qbit    = ~(up[`IDD_WORD_W-1] ^ divisor[`IDD_WORD_W-1]);
        res     = {up[`IDD_WORD_W-1:0], shl[`IDD_WORD_W-1:0]};
        flags.c = qbit;
      end
      default: res = opa; // test leaves value and clears carry
    endcase
    flags.z = (res == '0);
    flags.n = res[`IDD_ACC_W-1];
  end
endmodule

// ---- src/idd_mem_rmw.sv ----
// read-modify-write sequencer for one x data memory word
`timescale 1ns/1ps
`include "idd_consts.svh"
module idd_mem_rmw
  import idd_pkg::*;
(
  input logic                    mclk,
  logic                          sys_rst,
  logic                          start,
  logic [`IDD_WORD_W-1:0]        addr,
  logic [`IDD_WORD_W-1:0]        wdata,
  logic                          rvalid,
  output logic                   load,
  output logic                   writing,
  output idd_pkg::idd_xreq_t     xreq_r
);
  typedef enum logic [1:0] {RM_IDLE, RM_READ, RM_WAIT, RM_WRITE} idd_rm_t;
  idd_rm_t    st_r;
  idd_rm_t    st_nxt;
  idd_xreq_t  xreq_nxt;

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  // address is held from the read to the write, so the word
  // written back is always the word that was read
  always_comb
  begin
    st_nxt   = st_r;
    xreq_nxt = xreq_r;
    xreq_nxt.rd = 1'b0;
    xreq_nxt.wr = 1'b0;
    load     = 1'b0;
    writing  = (st_r == RM_WRITE);
    case (st_r)
      RM_IDLE:
        if (start)
        begin
          st_nxt        = RM_READ;
          xreq_nxt.rd   = 1'b1;
          xreq_nxt.addr = addr;
        end
      RM_READ:  st_nxt = RM_WAIT;
      RM_WAIT:
        if (rvalid)
        begin
          load           = 1'b1;
          st_nxt         = RM_WRITE;
          xreq_nxt.wr    = 1'b1; // RULE14
          xreq_nxt.wdata = wdata;
        end
      default:  st_nxt = RM_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_r   <= RM_IDLE;
      xreq_r <= '0;
    end
    else
    begin
      st_r   <= st_nxt;
      xreq_r <= xreq_nxt;
    end
  end
endmodule

// ---- src/idd_core.sv ----
// increment/decrement executor with divide-step support
// Function
// RULE1: increment_word adds one in place to an accumulator or an input register.
// RULE2: decrement_word subtracts one in place from an accumulator or input register.
// RULE3: load_effective_address post-increments or -decrements r0-r3 or sp.
// RULE4: test_word_and_decrement on a pointer decrements it and sets flags.
// RULE5: pointer updates by those two forms never stall the pipeline.
// RULE6: no test-and-decrement form increments a pointer or touches sp.
// RULE7: short addressing reaches the lowest 64 words of x memory.
// RULE8: absolute addressing reaches the whole 64k-word x memory.
// RULE9: memory increment supports a signed offset from the stack pointer.
// RULE10: the divide step takes a 16-bit divisor against a 32-bit dividend.
// RULE11: the divide step yields at most 16 quotient bits per sequence.
// RULE12: a word test on an accumulator always clears carry.
// RULE13: software clears carry before the first divide step.
// RULE14: memory increment and decrement write back to the address read.
`timescale 1ns/1ps
`include "idd_consts.svh"
module idd_core
  import idd_pkg::*;
(
  input logic                    mclk,
  logic                          sys_rst,
  idd_pkg::idd_instr_t           instr,
  logic [`IDD_WORD_W-1:0]        xm_rdata,
  logic                          xm_rvalid,
  output logic                   ready_r,
  output logic                   done_r,
  output logic                   ill_r,
  output logic                   div_over_r,
  output idd_pkg::idd_flags_t    sr_r,
  output idd_pkg::idd_regs_t     regs_r,
  output idd_pkg::idd_xreq_t     xm_req
);
  import idd_pkg::*;

  logic [`IDD_CNT_W-1:0]   div_cnt_r;
  logic [`IDD_CNT_W-1:0]   div_cnt_nxt;
  logic                    ready_nxt;
  logic                    done_nxt;
  logic                    ill_nxt;
  logic                    div_over_nxt;
  idd_flags_t              sr_nxt;
  idd_regs_t               regs_nxt;
  logic                    accept;
  logic                    legal;
  logic                    mem_start;
  logic [`IDD_WORD_W-1:0]  mem_addr;
  logic                    mem_load;
  logic                    mem_writing;
  idd_alu_t                alu_op;
  logic [`IDD_ACC_W-1:0]   alu_a;
  logic [`IDD_ACC_W-1:0]   alu_res;
  idd_flags_t              alu_flags;
  logic [`IDD_WORD_W-1:0]  divisor;
  logic                    mem_dec_r;
  logic                    mem_dec_nxt;
  logic [`IDD_WORD_W-1:0]  rd_addr_r;

  assign accept = instr.valid & ready_r;

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  // legality: selectors in range, pointer forms only on pointers
  always_comb
  begin
    legal = 1'b0;
    case (instr.op)
      OP_INCREMENT_WORD, OP_DECREMENT_WORD:
        case (instr.dst)
          DST_ACC: legal = (instr.sel < `IDD_N_ACC);
          DST_XIN: legal = (instr.sel < `IDD_N_XIN);
          DST_MEM: legal = 1'b1;
          default: legal = 1'b0;
        endcase
      OP_LEA_INC, OP_LEA_DEC:
        legal = (instr.dst == DST_PTR) && (instr.sel < `IDD_N_PTR); // RULE3
      OP_TEST_WORD_AND_DECREMENT_DEC: // no sp form and no increment form exists
        legal = (instr.dst == DST_PTR) && (instr.sel < `IDD_SP_IDX); // RULE6
      OP_TEST_WORD_AND_DECREMENT_ACC, OP_DIV:
        legal = (instr.sel < `IDD_N_ACC);
      default: legal = 1'b1;
    endcase
  end

  // effective address of a memory operand
  always_comb
  begin
    case (instr.am)
      AM_SHORT: // RULE7
        mem_addr = {`IDD_SHORT_PAD, instr.operand[`IDD_SHORT_W-1:0]};
      AM_STACK: // signed offset wraps in 16 bits
        mem_addr = 16'(regs_r.ptr[`IDD_SP_IDX] + instr.operand); // RULE9
      default:
        mem_addr = instr.operand; // RULE8
    endcase
  end

  assign mem_start = accept && legal && (instr.dst == DST_MEM) &&
                     (instr.op == OP_INCREMENT_WORD || instr.op == OP_DECREMENT_WORD);

  // --------------------------------------------------------------
  // arithmetic
  // --------------------------------------------------------------
  // divisor is the low input register index held in the operand field
  assign divisor = regs_r.xin[instr.operand[1:0]]; // RULE10

  // operand mux; 16-bit values ride in the upper half of the adder
  always_comb
  begin
    alu_op = ALU_TST;
    alu_a  = '0;
    if (mem_load)
    begin
      alu_op = mem_dec_r ? ALU_DEC : ALU_INC;
      alu_a  = {xm_rdata, `IDD_LOW_ZERO};
    end
    else
    begin
      case (instr.op)
        OP_INCREMENT_WORD, OP_LEA_INC: alu_op = ALU_INC;
        OP_DECREMENT_WORD, OP_LEA_DEC, OP_TEST_WORD_AND_DECREMENT_DEC: alu_op = ALU_DEC;
        OP_DIV:  alu_op = ALU_DIV;
        default: alu_op = ALU_TST;
      endcase
      case (instr.dst)
        DST_ACC: alu_a = regs_r.acc[instr.sel[0]];
        DST_XIN: alu_a = {regs_r.xin[instr.sel[1:0]], `IDD_LOW_ZERO};
        DST_PTR: alu_a = {regs_r.ptr[instr.sel], `IDD_LOW_ZERO};
        default: alu_a = '0;
      endcase
      if (instr.op == OP_TEST_WORD_AND_DECREMENT_ACC || instr.op == OP_DIV)
        alu_a = regs_r.acc[instr.sel[0]];
    end
  end

  idd_alu_step u_alu
  (
    .op      (alu_op),
    .opa     (alu_a),
    .divisor (divisor),
    .c_in    (sr_r.c), // RULE13
    .res     (alu_res),
    .flags   (alu_flags)
  );

  idd_mem_rmw u_rmw
  (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .start   (mem_start),
    .addr    (mem_addr),
    .wdata   (alu_res[`IDD_ACC_W-1:`IDD_WORD_W]),
    .rvalid  (xm_rvalid),
    .load    (mem_load),
    .writing (mem_writing),
    .xreq_r  (xm_req)
  );

  // --------------------------------------------------------------
  // execute
  // --------------------------------------------------------------
  // register ops retire in one cycle; memory ops hold ready low through
  // the write-back cycle so nothing slips between read and write
  always_comb
  begin
    regs_nxt     = regs_r;
    sr_nxt       = sr_r;
    div_cnt_nxt  = div_cnt_r;
    div_over_nxt = div_over_r;
    mem_dec_nxt  = mem_dec_r;
    ready_nxt    = ready_r;
    done_nxt     = 1'b0;
    ill_nxt      = 1'b0;
    if (mem_load)
      sr_nxt = alu_flags;
    if (mem_writing)
    begin
      ready_nxt = 1'b1; // RULE14
      done_nxt  = 1'b1;
    end
    if (accept && !legal)
      ill_nxt = 1'b1; // RULE6
    else if (mem_start)
    begin
      ready_nxt   = 1'b0;
      mem_dec_nxt = (instr.op == OP_DECREMENT_WORD);
    end
    else if (accept)
    begin
      done_nxt = (instr.op != OP_NOP);
      case (instr.op)
        OP_INCREMENT_WORD, OP_DECREMENT_WORD:
        begin
          sr_nxt = alu_flags;
          if (instr.dst == DST_ACC)
            regs_nxt.acc[instr.sel[0]] = alu_res; // RULE1 RULE2
          else
            regs_nxt.xin[instr.sel[1:0]] =
              alu_res[`IDD_ACC_W-1:`IDD_WORD_W]; // RULE1 RULE2
        end
        OP_LEA_INC, OP_LEA_DEC: // flags untouched
          regs_nxt.ptr[instr.sel] =
            alu_res[`IDD_ACC_W-1:`IDD_WORD_W]; // RULE3 RULE5
        OP_TEST_WORD_AND_DECREMENT_DEC:
        begin
          regs_nxt.ptr[instr.sel] =
            alu_res[`IDD_ACC_W-1:`IDD_WORD_W]; // RULE4 RULE5
          sr_nxt = alu_flags; // RULE4
        end
        OP_TEST_WORD_AND_DECREMENT_ACC:
        begin
          sr_nxt       = alu_flags; // RULE12
          sr_nxt.c     = 1'b0; // RULE12
          div_cnt_nxt  = '0;
          div_over_nxt = 1'b0;
        end
        OP_DIV:
          // a step beyond the sixteenth is refused and flagged
          if (div_cnt_r == `IDD_DIV_BITS)
          begin
            div_over_nxt = 1'b1; // RULE11
            ill_nxt      = 1'b1;
            done_nxt     = 1'b0;
          end
          else
          begin
            regs_nxt.acc[instr.sel[0]] = alu_res; // RULE10
            sr_nxt.c    = alu_flags.c;
            div_cnt_nxt = `IDD_CNT_W'(div_cnt_r + `IDD_CNT_ONE); // RULE11
          end
        default: done_nxt = 1'b0;
      endcase
    end
  end

  // state registers
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      regs_r     <= '0;
      sr_r       <= '0;
      div_cnt_r  <= '0;
      div_over_r <= 1'b0;
      mem_dec_r  <= 1'b0;
      ready_r    <= 1'b1;
      done_r     <= 1'b0;
      ill_r      <= 1'b0;
    end
    else
    begin
      regs_r     <= regs_nxt;
      sr_r       <= sr_nxt;
      div_cnt_r  <= div_cnt_nxt;
      div_over_r <= div_over_nxt;
      mem_dec_r  <= mem_dec_nxt;
      ready_r    <= ready_nxt;
      done_r     <= done_nxt;
      ill_r      <= ill_nxt;
    end
  end

  // last read address, only for checking the write-back
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rd_addr_r <= '0;
    else if (xm_req.rd)
      rd_addr_r <= xm_req.addr;
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  AST_INC_ACC: assert property (@(posedge mclk) disable iff (sys_rst) // RULE1
    accept && legal && instr.op == OP_INCREMENT_WORD && instr.dst == DST_ACC |=>
    regs_r.acc[$past(instr.sel[0])] ==
    $past(regs_r.acc[instr.sel[0]]) + {`IDD_ONE, `IDD_LOW_ZERO})
    else $error("accumulator increment wrong");

  AST_DEC_XIN: assert property (@(posedge mclk) disable iff (sys_rst) // RULE2
    accept && legal && instr.op == OP_DECREMENT_WORD && instr.dst == DST_XIN |=>
    regs_r.xin[$past(instr.sel[1:0])] ==
    $past(regs_r.xin[instr.sel[1:0]]) - `IDD_ONE)
    else $error("input register decrement wrong");

  AST_LEA_PTR: assert property (@(posedge mclk) disable iff (sys_rst) // RULE3
    accept && legal && instr.op == OP_LEA_INC |=>
    regs_r.ptr[$past(instr.sel)] == $past(regs_r.ptr[instr.sel]) + `IDD_ONE
    && $stable(sr_r))
    else $error("pointer post-increment wrong");

  AST_TEST_WORD_AND_DECREMENT_PTR: assert property (@(posedge mclk) disable iff (sys_rst) // RULE4
    accept && legal && instr.op == OP_TEST_WORD_AND_DECREMENT_DEC |=>
    sr_r.z == (regs_r.ptr[$past(instr.sel)] == '0) &&
    regs_r.ptr[$past(instr.sel)] == $past(regs_r.ptr[instr.sel]) - `IDD_ONE)
    else $error("test and decrement wrong");

  AST_NO_STALL: assert property (@(posedge mclk) disable iff (sys_rst) // RULE5
    accept && (instr.op == OP_LEA_INC || instr.op == OP_LEA_DEC ||
    instr.op == OP_TEST_WORD_AND_DECREMENT_DEC) |=> ready_r)
    else $error("pointer update stalled");

  AST_NO_SP_TEST_WORD_AND_DECREMENT: assert property (@(posedge mclk) // RULE6
    disable iff (sys_rst)
    accept && instr.op == OP_TEST_WORD_AND_DECREMENT_DEC && instr.sel == `IDD_SP_IDX |=>
    ill_r && $stable(regs_r.ptr[`IDD_SP_IDX]))
    else $error("stack pointer test and decrement accepted");

  AST_SHORT_ADDR: assert property (@(posedge mclk) // RULE7
    disable iff (sys_rst)
    mem_start && instr.am == AM_SHORT |=>
    xm_req.rd && xm_req.addr[`IDD_WORD_W-1:`IDD_SHORT_W] == '0)
    else $error("short address out of range");

  AST_DIV_LIMIT: assert property (@(posedge mclk) // RULE11
    disable iff (sys_rst)
    div_cnt_r == `IDD_DIV_BITS && accept && legal && instr.op == OP_DIV |=>
    div_over_r && $stable(div_cnt_r))
    else $error("seventeenth divide step taken");

  AST_TST_CARRY: assert property (@(posedge mclk) // RULE12
    disable iff (sys_rst)
    accept && legal && instr.op == OP_TEST_WORD_AND_DECREMENT_ACC |=> !sr_r.c && div_cnt_r == '0)
    else $error("word test left carry set");

  AST_RMW_ADDR: assert property (@(posedge mclk) // RULE14
    disable iff (sys_rst)
    xm_req.wr |-> xm_req.addr == rd_addr_r && !ready_r ##1 ready_r)
    else $error("write-back address differs from read");
endmodule

// ---- sim/test_idd_core.sv ----
// self-checking random bench for the increment/decrement core
`timescale 1ns/1ps
`include "idd_consts.svh"
module test_idd_core;
  import idd_pkg::*;
  // ------------------------------------------------------------
  // signals, expected state and counters
  // ------------------------------------------------------------
  logic                   mclk;
  logic                   sys_rst;
  idd_instr_t             instr;
  logic [`IDD_WORD_W-1:0] xm_rdata;
  logic                   xm_rvalid;
  logic                   ready_r;
  logic                   done_r;
  logic                   ill_r;
  logic                   div_over_r;
  idd_flags_t             sr_r;
  idd_regs_t              regs_r;
  idd_xreq_t              xm_req;
  idd_regs_t              m;
  logic                   p_done;
  logic                   p_ill;
  logic                   p_zn;
  logic                   p_z;
  logic                   p_n;
  logic                   p_tc;
  logic                   m_over;
  logic                   p_v;
  logic                   p_dv;
  logic                   m_c;
  int                     div_cnt;
  int                     miscompares;
  int                     n_compared;
  int                     cycles;

  idd_core i_dut (.mclk(mclk), .sys_rst(sys_rst), .instr(instr),
    .xm_rdata(xm_rdata), .xm_rvalid(xm_rvalid), .ready_r(ready_r),
    .done_r(done_r), .ill_r(ill_r), .div_over_r(div_over_r),
    .sr_r(sr_r), .regs_r(regs_r), .xm_req(xm_req));

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  always #4 mclk = ~mclk;

  // the whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // comparison, report and reference model
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one non-restoring step: old carry shifts in, the divisor is added
  // to the upper word when signs differ, else subtracted
  function automatic logic [32:0] div_step(input logic [31:0] a,
                                           input logic [15:0] dv,
                                           input logic        c);
    logic [31:0] s;
    logic [15:0] u;
    s = {a[30:0], c};
    if (a[31] != dv[15])
      u = s[31:16] + dv;
    else
      u = s[31:16] - dv;
    return {u[15] == dv[15], u, s[15:0]};
  endfunction

  // accumulator words live in the upper half, hence 0x10000 steps
  task automatic predict(input idd_instr_t i);
    logic [31:0] a;
    logic        inc;
    inc = (i.op == OP_INCREMENT_WORD);
    p_ill = 1'b0;
    p_zn = 1'b0;
    p_tc = 1'b0;
    p_dv = 1'b0;
    if (i.valid)
      case (i.op)
        OP_INCREMENT_WORD, OP_DECREMENT_WORD:
          if (i.dst == DST_ACC && i.sel < 3'h2)
          begin
            a = m.acc[i.sel] + (inc ? 32'h0001_0000 : 32'hffff_0000);
            p_v = inc ? (!m.acc[i.sel][31] && a[31])
                      : (m.acc[i.sel][31] && !a[31]);
            m.acc[i.sel] = a;
            p_z = (a == 32'h0);
            p_n = a[31];
            p_zn = 1'b1;
          end
          else if (i.dst == DST_XIN && i.sel < 3'h3)
            m.xin[i.sel] = m.xin[i.sel] + (inc ? 16'h0001 : 16'hffff);
          else
            p_ill = 1'b1;
        OP_LEA_INC, OP_LEA_DEC:
          if (i.dst == DST_PTR && i.sel < 3'h5)
            m.ptr[i.sel] = m.ptr[i.sel] +
              (i.op == OP_LEA_INC ? 16'h0001 : 16'hffff);
          else
            p_ill = 1'b1;
        OP_TEST_WORD_AND_DECREMENT_DEC:
          if (i.dst == DST_PTR && i.sel < 3'h4)
            m.ptr[i.sel] = m.ptr[i.sel] - 16'h0001;
          else
            p_ill = 1'b1;
        OP_TEST_WORD_AND_DECREMENT_ACC:
        begin
          p_tc = 1'b1;
          m_c = 1'b0;
          div_cnt = 0;
          m_over = 1'b0;
        end
        OP_DIV:
          if (div_cnt == 16)
          begin
            p_ill = 1'b1;
            m_over = 1'b1;
          end
          else
          begin
            div_cnt = div_cnt + 1;
            p_dv = 1'b1;
            {m_c, m.acc[i.sel]} = div_step(m.acc[i.sel],
              m.xin[i.operand[1:0]], m_c);
          end
        default: ;
      endcase
    p_done = i.valid && !p_ill;
  endtask

  function automatic logic [15:0] mem_addr(input idd_am_t am,
                                           input logic [15:0] o);
    if (am == AM_SHORT)
      return {10'h000, o[5:0]};
    if (am == AM_ABS)
      return o;
    return m.ptr[4] + o;
  endfunction

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic check_state();
    int k;
    check(done_r, p_done);
    check(ill_r, p_ill);
    check(ready_r, 1'b1);
    check(div_over_r, m_over);
    for (k = 0; k < 2; k++)
      check(regs_r.acc[k], m.acc[k]);
    for (k = 0; k < 3; k++)
      check(regs_r.xin[k], m.xin[k]);
    for (k = 0; k < 5; k++)
      check(regs_r.ptr[k], m.ptr[k]);
    if (p_zn)
      check({sr_r.z, sr_r.n, sr_r.v}, {p_z, p_n, p_v});
    if (p_tc)
      check(sr_r.c, 1'b0);
    if (p_dv)
      check(sr_r.c, m_c);
  endtask

  // checks the previous op while the next one is already offered,
  // so register ops run back to back with no idle cycle
  task automatic step(input idd_instr_t i);
    instr <= i;
    @(negedge mclk);
    check_state();
    predict(i);
    @(posedge mclk);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    instr <= '0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    m = '0;
    {p_done, p_ill, p_zn, p_tc, p_dv, m_c, m_over} = 7'h00;
    div_cnt = 0;
    @(negedge mclk);
    check_state();
    @(posedge mclk);
  endtask

  // memory answers lat cycles after the read; released data is scrambled
  task automatic mem_op(input idd_op_t op, input idd_am_t am,
                        input logic [15:0] o, input int lat);
    logic [15:0] d;
    logic [15:0] ad;
    d = 16'($urandom);
    ad = mem_addr(am, o);
    instr <= '{1'b1, op, DST_MEM, am, 3'h0, o};
    xm_rdata <= ~d;
    @(posedge mclk);
    instr.valid <= 1'b0;
    @(negedge mclk);
    check({xm_req.rd, ready_r}, 2'b10);
    check(xm_req.addr, ad);
    repeat (lat - 1) @(posedge mclk);
    xm_rvalid <= 1'b1;
    xm_rdata <= d;
    @(posedge mclk);
    xm_rvalid <= 1'b0;
    xm_rdata <= ~d;
    @(negedge mclk);
    check({xm_req.wr, done_r, ready_r}, 3'b100);
    check(xm_req.addr, ad);
    check(xm_req.wdata, 16'(d + (op == OP_INCREMENT_WORD ? 16'h1 : 16'hffff)));
    @(posedge mclk);
    @(negedge mclk);
    check({xm_req.wr, done_r, ready_r}, 3'b011);
    @(posedge mclk);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    idd_instr_t r;
    mclk = 1'b0;
    sys_rst = 1'b1;
    instr = '0;
    xm_rdata = 16'h0000;
    xm_rvalid = 1'b0;
    miscompares = 0;
    n_compared = 0;
    cycles = 0;
    void'($urandom(24405));
    do_reset();
    // corners: stack pointer wrap, refused forms, accumulator sign
    step('{1'b1, OP_LEA_DEC, DST_PTR, AM_SHORT, 3'h4, 16'h0000});
    step('{1'b1, OP_TEST_WORD_AND_DECREMENT_DEC, DST_PTR, AM_SHORT, 3'h4, 16'h0000});
    step('{1'b1, OP_LEA_INC, DST_ACC, AM_SHORT, 3'h0, 16'h0000});
    step('{1'b1, OP_DECREMENT_WORD, DST_ACC, AM_SHORT, 3'h0, 16'h0000});
    step('{1'b1, OP_INCREMENT_WORD, DST_ACC, AM_SHORT, 3'h0, 16'h0000});
    // random register traffic, illegal selectors included
    repeat (300)
    begin
      r.valid = ($urandom_range(4) != 0);
      r.op = idd_op_t'($urandom_range(5, 1));
      r.dst = idd_dst_t'($urandom_range(2));
      r.am = AM_SHORT;
      r.sel = 3'($urandom_range(7));
      r.operand = 16'($urandom);
      step(r);
    end
    step('0);
    // memory forms in all three addressing modes, both ends of the short window included, then at random
    mem_op(OP_INCREMENT_WORD, AM_SHORT, 16'hffff, 2);
    mem_op(OP_DECREMENT_WORD, AM_SHORT, 16'h0040, 3);
    mem_op(OP_INCREMENT_WORD, AM_ABS, 16'hffff, 2);
    mem_op(OP_DECREMENT_WORD, AM_ABS, 16'hc200, 4);
    mem_op(OP_INCREMENT_WORD, AM_STACK, 16'hffdb, 2);
    repeat (8)
      mem_op(idd_op_t'($urandom_range(2, 1)),
             idd_am_t'($urandom_range(2)), 16'($urandom),
             $urandom_range(5, 2));
    // carry cleared first, then one step too many
    step('{1'b1, OP_TEST_WORD_AND_DECREMENT_ACC, DST_ACC, AM_SHORT, 3'h1, 16'h0000});
    repeat (17)
      step('{1'b1, OP_DIV, DST_ACC, AM_SHORT, 3'h1, 16'h0000});
    step('{1'b1, OP_TEST_WORD_AND_DECREMENT_ACC, DST_ACC, AM_SHORT, 3'h1, 16'h0000});
    step('0);
    // reset again in mid-run, then prove the core works afterwards
    do_reset();
    step('{1'b1, OP_INCREMENT_WORD, DST_XIN, AM_SHORT, 3'h2, 16'h0000});
    step('0);
    summarize();
  end
endmodule
